// ---- core/slf_defines.vh ----
// Constants for the supply loss and fail mode controller
`ifndef SLF_DEFINES_VH
`define SLF_DEFINES_VH
`define SLF_CLK_HZ 50000000
`define SLF_DGL_US 200
`define SLF_WD_SHORT_MS 32
`define SLF_WD_LONG_MS 128
`define SLF_CTRL_ADDR 8'h00
`define SLF_STAT_ADDR 8'h04
`define SLF_FAULT_ADDR 8'h08
`define SLF_CTRL_EXT 0
`define SLF_CTRL_WD 1
`define SLF_CTRL_WDSEL 2
`define SLF_ST_LIMP 0
`define SLF_ST_FAIL 1
`define SLF_ST_SPIF 2
`define SLF_ST_AWAKE 3
`define SLF_ST_VBATLOSS 4
`define SLF_ST_GNDLOSS 5
`define SLF_ST_VCCLOSS 6
`define SLF_CTRL_RESET 3'h0
`define SLF_NUM_SYNC 5
`define SLF_SYNC_RESET 5'h06
`define SLF_NUM_FAULTS 8
`define SLF_NUM_CH 5
`define SLF_NUM_IN 4
`define SLF_HTRANS_NONSEQ 2'h2
`define SLF_HTRANS_SEQ 2'h3
`define SLF_ADDR_LSB 2
`define SLF_ADDR_MSB 7
`define SLF_CNT_W 23
`endif

// ---- core/slf_mode_ctrl.v ----
// Mode supervision: sleep/wake, supply loss, fail mode and AHB-Lite registers
`timescale 1ns/1ps
`include "slf_defines.vh"

module slf_mode_ctrl #(
    parameter DGL_CYCLES = (`SLF_CLK_HZ / 1000000) * `SLF_DGL_US,
    parameter WD_SHORT_CYCLES = (`SLF_CLK_HZ / 1000) * `SLF_WD_SHORT_MS,
    parameter WD_LONG_CYCLES = (`SLF_CLK_HZ / 1000) * `SLF_WD_LONG_MS
) (
    input wire hclk,
    input wire hresetn,
    input wire ce,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire wake,
    input wire wake_by_reset_pin,
    input wire vbat_above_por,
    input wire vcc_above_por,
    input wire gnd_lost,
    input wire fail_mode_request,
    input wire host_reset_n_input,
    input wire [`SLF_NUM_IN-1:0] direct_channel_inputs,
    input wire [`SLF_NUM_CH-1:0] pwm_channel_drive,
    input wire [`SLF_NUM_FAULTS-1:0] fault_events,
    output reg [`SLF_NUM_CH-1:0] power_channel_outputs,
    output reg external_switch_control_output,
    output wire wake_report_o,
    output reg wake_report_oe,
    output wire sleep_mode,
    output wire fail_mode,
    output reg power_off
);

// =====================================================
// Input synchronisers
// =====================================================
wire [`SLF_NUM_SYNC-1:0] raw_in;
wire [`SLF_NUM_SYNC-1:0] sync_in;
assign raw_in = {fail_mode_request, gnd_lost, vcc_above_por, vbat_above_por, wake};

// Supply-ok bits reset high so a reset release never fakes a power loss
localparam [`SLF_NUM_SYNC-1:0] SYNC_RST = `SLF_SYNC_RESET;
genvar gi;
generate
    for (gi = 0; gi < `SLF_NUM_SYNC; gi = gi + 1) begin : g_sync
        reg meta;
        reg stable;
        always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                meta <= SYNC_RST[gi];
                stable <= SYNC_RST[gi];
            end else if (ce) begin
                meta <= raw_in[gi];
                stable <= meta;
            end
        end
        assign sync_in[gi] = stable;
    end
endgenerate

wire awake;
wire vbat_ok;
wire vcc_ok;
wire gnd_loss;
wire limp_in;
assign awake = sync_in[0];
assign vbat_ok = sync_in[1];
assign vcc_ok = sync_in[2];
assign gnd_loss = sync_in[3];
assign limp_in = sync_in[4];

// =====================================================
// Power-off detection and internal reset
// =====================================================
// Power-off is registered so the derived reset never glitches
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        power_off <= 1'b0;
    end else if (ce) begin
        power_off <= !vbat_ok && !vcc_ok;
    end
end

wire core_rst_n;
assign core_rst_n = hresetn & ~power_off;

// =====================================================
// Fail request deglitch
// =====================================================
reg [`SLF_CNT_W-1:0] dgl_cnt;
reg ilimp;

always @(posedge hclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
        dgl_cnt <= {`SLF_CNT_W{1'b0}};
        ilimp <= 1'b0;
    end else if (ce) begin
        if (limp_in == ilimp) begin
            dgl_cnt <= {`SLF_CNT_W{1'b0}};
        end else if (dgl_cnt >= DGL_CYCLES[`SLF_CNT_W-1:0] - 1'b1) begin
            dgl_cnt <= {`SLF_CNT_W{1'b0}};
            ilimp <= limp_in;
        end else begin
            dgl_cnt <= dgl_cnt + 1'b1;
        end
    end
end

// =====================================================
// AHB-Lite slave
// =====================================================
reg dp_write;
reg dp_read;
reg rd_ready;
reg [`SLF_ADDR_MSB:0] dp_addr;
reg [2:0] ctrl;
reg [`SLF_NUM_FAULTS-1:0] fault_flags;
reg comm_err;
reg spi_fail;

wire addr_valid;
assign addr_valid = hsel && hready && (htrans == `SLF_HTRANS_NONSEQ || htrans == `SLF_HTRANS_SEQ);

// Reads take one wait state so a preceding write is always visible
assign hreadyout = !(dp_read && !rd_ready);
assign hresp = 1'b0;

reg [31:0] status_word;
always @* begin
    status_word = 32'h00000000;
    status_word[`SLF_ST_LIMP] = limp_in;
    status_word[`SLF_ST_FAIL] = fail_mode;
    status_word[`SLF_ST_SPIF] = spi_fail;
    status_word[`SLF_ST_AWAKE] = awake;
    status_word[`SLF_ST_VBATLOSS] = !vbat_ok;
    status_word[`SLF_ST_GNDLOSS] = gnd_loss;
    status_word[`SLF_ST_VCCLOSS] = !vcc_ok;
end

reg [31:0] read_value;
always @* begin
    read_value = 32'h00000000;
    case (dp_addr)
        `SLF_CTRL_ADDR: read_value = {29'h00000000, ctrl};
        `SLF_STAT_ADDR: read_value = status_word;
        `SLF_FAULT_ADDR: read_value = {24'h000000, fault_flags};
        default: read_value = 32'h00000000;
    endcase
end

wire ctrl_wr;
wire fault_wr;
assign ctrl_wr = dp_write && (dp_addr == `SLF_CTRL_ADDR);
assign fault_wr = dp_write && (dp_addr == `SLF_FAULT_ADDR);

always @(posedge hclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
        dp_write <= 1'b0;
        dp_read <= 1'b0;
        rd_ready <= 1'b0;
        dp_addr <= 8'h00;
        hrdata <= 32'h00000000;
    end else if (ce) begin
        if (dp_read && !rd_ready) begin
            rd_ready <= 1'b1;
            // Without the logic supply the read path is dead
            hrdata <= vcc_ok ? read_value : 32'h00000000;
        end else begin
            rd_ready <= 1'b0;
            dp_write <= addr_valid && hwrite;
            dp_read <= addr_valid && !hwrite;
            if (addr_valid) begin
                dp_addr <= {haddr[`SLF_ADDR_MSB:`SLF_ADDR_LSB], 2'h0};
            end
        end
    end
end

// =====================================================
// Control and fault registers
// =====================================================
always @(posedge hclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
        ctrl <= `SLF_CTRL_RESET;
        fault_flags <= {`SLF_NUM_FAULTS{1'b0}};
    end else if (ce) begin
        if (ctrl_wr && vcc_ok) begin
            ctrl <= hwdata[`SLF_CTRL_WDSEL:0];
        end
        // Registers survive a battery loss while power-off is not set
        // A new fault wins over a clear in the same cycle
        fault_flags <= (fault_flags & ~(fault_wr ? hwdata[`SLF_NUM_FAULTS-1:0] : {`SLF_NUM_FAULTS{1'b0}}))
            | fault_events;
    end
end

// =====================================================
// Serial watchdog and communication error
// =====================================================
reg [`SLF_CNT_W-1:0] wd_cnt;
wire [`SLF_CNT_W-1:0] wd_limit;
wire kick;
wire bad_kick;
wire wd_timeout;
wire wd_expire;
assign wd_limit = ctrl[`SLF_CTRL_WDSEL] ? WD_LONG_CYCLES[`SLF_CNT_W-1:0] : WD_SHORT_CYCLES[`SLF_CNT_W-1:0];
assign kick = ctrl_wr && vcc_ok && (hwdata[`SLF_CTRL_WD] != ctrl[`SLF_CTRL_WD]);
assign bad_kick = ctrl_wr && vcc_ok && (hwdata[`SLF_CTRL_WD] == ctrl[`SLF_CTRL_WD]);
assign wd_timeout = (wd_cnt >= wd_limit - 1'b1);
// A good kick removes a pending timeout instead of being overruled by it
assign wd_expire = wd_timeout && !kick;

always @(posedge hclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
        wd_cnt <= {`SLF_CNT_W{1'b0}};
        comm_err <= 1'b0;
        spi_fail <= 1'b0;
    end else if (ce) begin
        // Lost logic supply stops all kicks, so the count runs out
        if (!awake || kick) begin
            wd_cnt <= {`SLF_CNT_W{1'b0}};
        end else if (!wd_timeout) begin
            wd_cnt <= wd_cnt + 1'b1;
        end
        if (awake && (wd_expire || bad_kick)) begin
            comm_err <= 1'b1;
            spi_fail <= 1'b1;
        end else if (kick && !ilimp) begin
            comm_err <= 1'b0;
            spi_fail <= 1'b0;
        end
    end
end

assign fail_mode = ilimp | comm_err;
assign sleep_mode = !awake;

// =====================================================
// Wake reporting on the dual-purpose clock pin
// =====================================================
reg awake_d;
reg woke_by_reset;
reg woke_in_batloss;
reg next_wake_report_oe;
wire wake_rise;
assign wake_rise = awake && !awake_d;

// Held off in the first cycle of a wake until its cause is latched
always @* begin
    next_wake_report_oe = 1'b0;
    if (awake && !wake_rise && !host_reset_n_input) begin
        next_wake_report_oe = !woke_by_reset && !woke_in_batloss;
    end
end

always @(posedge hclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
        awake_d <= 1'b0;
        woke_by_reset <= 1'b0;
        woke_in_batloss <= 1'b0;
        wake_report_oe <= 1'b0;
    end else if (ce) begin
        awake_d <= awake;
        if (wake_rise) begin
            woke_by_reset <= wake_by_reset_pin;
            woke_in_batloss <= !vbat_ok;
        end
        wake_report_oe <= next_wake_report_oe;
    end
end

assign wake_report_o = 1'b1;

// =====================================================
// Output control
// =====================================================
wire [`SLF_NUM_CH-1:0] direct_drive;

// Channels without a direct input stay off in fail mode
genvar ci;
generate
    for (ci = 0; ci < `SLF_NUM_CH; ci = ci + 1) begin : g_direct
        if (ci < `SLF_NUM_IN) begin : g_in
            assign direct_drive[ci] = direct_channel_inputs[ci];
        end else begin : g_none
            assign direct_drive[ci] = 1'b0;
        end
    end
endgenerate

reg [`SLF_NUM_CH-1:0] next_power_channel_outputs;
reg next_external_switch_control_output;

always @* begin
    next_power_channel_outputs = pwm_channel_drive;
    if (!awake || !vbat_ok || gnd_loss) begin
        next_power_channel_outputs = {`SLF_NUM_CH{1'b0}};
    end else if (fail_mode) begin
        next_power_channel_outputs = direct_drive;
    end
    // The external output keeps its setting through a battery loss
    next_external_switch_control_output = awake && !fail_mode && !gnd_loss && ctrl[`SLF_CTRL_EXT];
end

always @(posedge hclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
        power_channel_outputs <= {`SLF_NUM_CH{1'b0}};
        external_switch_control_output <= 1'b0;
    end else if (ce) begin
        power_channel_outputs <= next_power_channel_outputs;
        external_switch_control_output <= next_external_switch_control_output;
    end
end

endmodule

// ---- bench/slf_mode_asserts.sv ----
// Checker for the mode controller ports
`timescale 1ns/1ps
`include "slf_defines.vh"
module slf_mode_asserts (
    input wire hclk,
    input wire hresetn,
    input wire host_reset_n_input,
    input wire gnd_lost,
    input wire fail_mode_request,
    input wire [`SLF_NUM_CH-1:0] power_channel_outputs,
    input wire external_switch_control_output,
    input wire wake_report_o,
    input wire wake_report_oe,
    input wire sleep_mode,
    input wire fail_mode,
    input wire power_off
);
    // ==========
    // Properties
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Two cycles: outputs lag the mode flops by one edge
    a_sleep_off: assert property (sleep_mode [*2] |-> power_channel_outputs == 5'h0)
        else $error("channel on in sleep");
    a_oe_sleep: assert property (sleep_mode [*2] |-> !wake_report_oe)
        else $error("clock pin driven in sleep");
    a_oe_pin_high: assert property (wake_report_oe |-> wake_report_o)
        else $error("clock pin driven low");
    a_oe_in_reset: assert property (wake_report_oe |-> !$past(host_reset_n_input))
        else $error("wake report outside host reset");
    a_poff_clear: assert property (power_off |-> power_channel_outputs == 5'h0
        && !external_switch_control_output && !fail_mode)
        else $error("state kept in power off");
    a_gnd_off: assert property (gnd_lost [*5] |-> power_channel_outputs == 5'h0)
        else $error("channel on without ground");
    a_ch4_fail: assert property (fail_mode [*2] |-> !power_channel_outputs[4])
        else $error("channel without input on in fail mode");
    a_fail_req: assert property (fail_mode_request [*8] ##1 fail_mode_request [*8]
        |=> fail_mode || power_off)
        else $error("fail request ignored");
endmodule

// ---- bench/slf_host.sv ----
// Host model: AHB-Lite master on the register port
`timescale 1ns/1ps
module slf_host (
    input wire hclk,
    input wire hready,
    input wire [31:0] hrdata,
    output reg hsel = 1'h0,
    output reg [31:0] haddr = 32'h0,
    output reg [1:0] htrans = 2'h0,
    output reg hwrite = 1'h0,
    output reg [2:0] hsize = 3'h2,
    output reg [31:0] hwdata = 32'h0
);
    // ==========
    // Transfers
    // Released haddr, and hwdata on reads, show inverted data; hwrite keeps its value
    task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
        begin
            @(posedge hclk);
            hsel <= 1'h1;
            haddr <= {24'h0, a};
            htrans <= 2'h2;
            hwrite <= w;
            @(posedge hclk);
            while (!hready) @(posedge hclk);
            hsel <= 1'h0;
            htrans <= 2'h0;
            haddr <= ~haddr;
            hwdata <= w ? d : ~hwdata;
            @(posedge hclk);
            while (!hready) @(posedge hclk);
            q = hrdata;
        end
    endtask
endmodule

// ---- bench/slf_mode_ctrl_tb.sv ----
// Self-checking bench for the mode controller
`timescale 1ns/1ps
`include "slf_defines.vh"
module slf_mode_ctrl_tb;
    reg hclk = 0, hresetn = 0, ce = 1, wake = 0, wbr = 0, vbat = 1, vcc = 1, gnd = 0, freq = 0, hrst_n = 1;
    reg [3:0] din = 0;
    reg [4:0] pwm = 0;
    reg [7:0] fev = 0;
    reg [31:0] q;
    reg wdb = 0;
    integer error_cnt = 0, n_tests = 0, seed = 32'h8aa0cfe3, i;
    wire [31:0] haddr, hwdata, hrdata;
    wire [1:0] htrans;
    wire [2:0] hsize;
    wire [4:0] pco;
    wire hsel, hwrite, hrdy, hresp, oe, wo, slp, fm, poff, ext;
    initial begin
        forever #10 hclk = ~hclk;
    end
    // Short counts keep the run brief
    slf_mode_ctrl #(.DGL_CYCLES(8), .WD_SHORT_CYCLES(3000), .WD_LONG_CYCLES(6000)) DUT (.hclk(hclk),
        .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hrdy), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .wake(wake),
        .wake_by_reset_pin(wbr), .vbat_above_por(vbat), .vcc_above_por(vcc), .gnd_lost(gnd),
        .fail_mode_request(freq), .host_reset_n_input(hrst_n), .direct_channel_inputs(din),
        .pwm_channel_drive(pwm), .fault_events(fev), .power_channel_outputs(pco),
        .external_switch_control_output(ext), .wake_report_o(wo), .wake_report_oe(oe), .sleep_mode(slp),
        .fail_mode(fm), .power_off(poff));
    slf_host host (.hclk(hclk), .hready(hrdy), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    // ==========
    // Helpers and model
    task ck(input [31:0] s, input [31:0] e);
        begin
            n_tests = n_tests + 1;
            if (s !== e) begin
                error_cnt = error_cnt + 1;
                $display("unexpected at %0t: got %h want %h", $time, s, e);
            end
        end
    endtask
    task cy(input integer n);
        repeat (n) @(posedge hclk);
    endtask
    task rd(input [7:0] a);
        host.xfer(1'h0, a, 32'h0, q);
    endtask
    // Each control write must flip the watchdog bit
    task ctl(input e);
        begin
            wdb = ~wdb;
            host.xfer(1'h1, `SLF_CTRL_ADDR, {30'h0, wdb, e}, q);
        end
    endtask
    task wf(input v);
        begin
            i = 0;
            while (fm !== v && i < 4000) begin
                @(posedge hclk);
                i = i + 1;
            end
            ck(fm, v);
        end
    endtask
    function [4:0] mo(input f);
        mo = f ? {1'h0, din} : pwm;
    endfunction
    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
            if (error_cnt == 0 && n_tests > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        #800000;
        error_cnt = error_cnt + 1;
        give_verdict;
    end
    // ==========
    // Scenarios
    initial begin
        cy(8);
        ck({pco, ext, oe, fm, poff, hrdy, hresp, slp}, 12'h005);
        hresetn <= 1;
        wake <= 1;
        din <= 4'($random(seed));
        cy(6);
        ctl(1'h1);
        for (i = 0; i < 4; i = i + 1) begin
            pwm <= 5'($random(seed));
            cy(5);
            ck(pco, mo(1'h0));
        end
        ck(ext, 1'h1);
        rd(`SLF_STAT_ADDR);
        ck(q[3], 1'h1);
        ck(slp, 1'h0);
        for (i = 0; i < 8; i = i + 1) begin
            fev <= 8'h1 << i;
            cy(1);
            fev <= 8'h0;
            cy(4);
            rd(`SLF_FAULT_ADDR);
            ck(q[7:0], 8'h1 << i);
            host.xfer(1'h1, `SLF_FAULT_ADDR, 32'hff, q);
            rd(`SLF_FAULT_ADDR);
            ck(q, 32'h0);
        end
        $display("normal mode test done");
        freq <= 1;
        cy(4);
        rd(`SLF_STAT_ADDR);
        ck(q[0], 1'h1);
        wf(1'h1);
        din <= 4'($random(seed));
        cy(5);
        ck({pco, ext}, {mo(1'h1), 1'h0});
        freq <= 0;
        wf(1'h0);
        freq <= 1;
        cy(4);
        freq <= 0;
        cy(20);
        ck(fm, 1'h0);
        ctl(1'h1);
        $display("fail mode test done");
        vbat <= 0;
        cy(5);
        ck({pco, ext}, 6'h1);
        rd(`SLF_CTRL_ADDR);
        ck(q[2:0], {1'h0, wdb, 1'h1});
        hrst_n <= 0;
        wake <= 0;
        cy(6);
        wake <= 1;
        cy(6);
        ck(oe, 1'h0);
        vbat <= 1;
        wake <= 0;
        cy(6);
        ck({pco, oe, slp}, 7'h01);
        wake <= 1;
        cy(6);
        ck({oe, wo}, 2'h3);
        hrst_n <= 1;
        cy(3);
        ck(oe, 1'h0);
        hrst_n <= 0;
        wake <= 0;
        cy(6);
        wbr <= 1;
        wake <= 1;
        cy(6);
        ck(oe, 1'h0);
        wbr <= 0;
        hrst_n <= 1;
        ctl(1'h1);
        $display("wake report test done");
        pwm <= 5'h1f;
        gnd <= 1;
        cy(5);
        ck(pco, 5'h0);
        gnd <= 0;
        cy(5);
        ck(pco, 5'h1f);
        vbat <= 0;
        vcc <= 0;
        cy(5);
        ck({poff, pco, ext}, 7'h40);
        vbat <= 1;
        vcc <= 1;
        cy(6);
        rd(`SLF_CTRL_ADDR);
        ck(q, 32'h0);
        wdb = 0;
        ctl(1'h1);
        $display("supply loss test done");
        vcc <= 0;
        cy(5);
        rd(`SLF_STAT_ADDR);
        ck(q, 32'h0);
        wf(1'h1);
        vcc <= 1;
        cy(5);
        rd(`SLF_STAT_ADDR);
        ck(q[2], 1'h1);
        ctl(1'h1);
        cy(5);
        ck(fm, 1'h0);
        host.xfer(1'h1, `SLF_CTRL_ADDR, {30'h0, wdb, 1'h1}, q);
        wf(1'h1);
        // Long select must outlast the short limit, then still expire
        wdb = ~wdb;
        host.xfer(1'h1, `SLF_CTRL_ADDR, {29'h0, 1'h1, wdb, 1'h1}, q);
        cy(3500);
        ck(fm, 1'h0);
        wf(1'h1);
        $display("watchdog test done");
        give_verdict;
    end
endmodule
bind slf_mode_ctrl slf_mode_asserts chk (.hclk, .hresetn, .host_reset_n_input, .gnd_lost, .fail_mode_request,
    .power_channel_outputs, .external_switch_control_output, .wake_report_o, .wake_report_oe, .sleep_mode,
    .fail_mode, .power_off);
